/* File: include/elr_pkg.sv */
// constants for the event log and disturbance recorder block
// assumes a 100 MHz system clock and a simple word register port
package elr_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sizes
  localparam int EV_DEPTH_DFLT = 200;
  localparam int SAMP_DEPTH_DFLT = 1024;
  localparam int TRIG_W_DFLT = 16;
  localparam int MAX_RECORDS = 12;
  localparam int MAX_CHANNELS = 12;
  localparam int PCT_MAX = 100;
  // register byte offsets
  localparam logic [7:0] A_EV_CTRL = 8'h00;
  localparam logic [7:0] A_EV_CMD = 8'h04;
  localparam logic [7:0] A_EV_COUNT = 8'h08;
  localparam logic [7:0] A_EV_SEL = 8'h0c;
  localparam logic [7:0] A_EV_CODE = 8'h10;
  localparam logic [7:0] A_EV_TIME = 8'h14;
  localparam logic [7:0] A_EV_FAULT = 8'h18;
  localparam logic [7:0] A_PRI_RATIO = 8'h1c;
  localparam logic [7:0] A_DR_CTRL = 8'h20;
  localparam logic [7:0] A_DR_LEN = 8'h24;
  localparam logic [7:0] A_DR_TRIG_COL = 8'h28;
  localparam logic [7:0] A_DR_CMD = 8'h2c;
  localparam logic [7:0] A_DR_STATUS = 8'h30;
  localparam logic [7:0] A_DR_CHCNT = 8'h34;
  localparam logic [7:0] A_DR_MAX_CAPTURE_LENGTH = 8'h38;
  localparam logic [7:0] A_DR_RSEL = 8'h3c;
  localparam logic [7:0] A_DR_RTIME = 8'h40;
  localparam logic [7:0] A_DR_RDATA = 8'h44;
  // field positions
  localparam int EC_ORDER = 0;
  localparam int EC_SCALE = 1;
  localparam int EC_POPUP = 2;
  localparam int EC_SYNCFMT = 3;
  localparam int CMD_WIPE = 0;
  localparam int CMD_ACK = 1;
  localparam int DC_EN = 0;
  localparam int DC_OVW = 1;
  localparam int DC_SR_LSB = 4;
  localparam int DC_PCT_LSB = 8;
  localparam int RC_MAN = 0;
  localparam int RC_ADD = 1;
  localparam int RC_CLR = 2;
  localparam int RC_FREE = 3;
  localparam int RC_CODE_LSB = 8;
  // reset values
  localparam logic [3:0] EV_CTRL_RST = 4'h0;
  localparam logic [15:0] PRI_RATIO_RST = 16'h0001;
  localparam logic [15:0] DR_LEN_RST = 16'h0064;
  localparam logic [3:0] SR_RST = 4'h0;
  localparam logic [6:0] PCT_RST = 7'h32;
  // sample interval codes
  localparam logic [3:0] SR_8C = 4'h2;
  localparam logic [3:0] SR_20MS = 4'h4;
  localparam logic [3:0] SR_LAST = 4'hb;
  // interval in ms per code, zero for waveform rates
  localparam logic [15:0] SR_MS [12] = '{16'h0, 16'h0, 16'h0, 16'h000a,
    16'h0014, 16'h00c8, 16'h03e8, 16'h1388, 16'h2710, 16'h3a98, 16'h7530,
    16'hea60};
  // channel signal codes
  localparam logic [5:0] CH_DI = 6'h10;
  localparam logic [5:0] CH_ARC = 6'h11;
  localparam logic [5:0] CH_DERIV_BASE = 6'h20;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPT, ST_FULL} elr_state_t;
endpackage

/* File: hw/elr_top.sv */
// event buffer with display formatting and a disturbance recorder
// assumes synchronous inputs and a master that never waits on reads
`timescale 1ns/1ps
module elr_top #(
  parameter int EV_DEPTH = elr_pkg::EV_DEPTH_DFLT,
  parameter int SAMP_DEPTH = elr_pkg::SAMP_DEPTH_DFLT,
  parameter int TRIG_W = elr_pkg::TRIG_W_DFLT,
  parameter int MS_CYCLES = elr_pkg::MS_CYCLES_DFLT
) (
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // async reset, low
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic i_ev_valid, // new event pulse
  input wire logic [7:0] i_ev_chan, // event channel
  input wire logic [7:0] i_ev_code, // event code
  input wire logic [15:0] i_ev_fault, // fault value, per unit
  input wire logic [31:0] i_time, // relay clock
  input wire logic i_time_synced, // relay clock synchronised
  input wire logic i_wave_tick, // 32 per cycle sample pulse
  input wire logic [15:0] i_sample, // sample word
  input wire logic [TRIG_W-1:0] i_trig, // trigger source levels
  input wire logic [63:0] i_chan_avail, // signal exists now
  output logic o_popup, // new event indication
  output logic [1:0] o_rec_status // recorder state
);
  import elr_pkg::*;
  localparam int EVW = $clog2(EV_DEPTH);
  localparam int SW = $clog2(SAMP_DEPTH);

  function automatic logic hit(input logic wr, input logic [7:0] a,
                               input logic [7:0] k);
    return wr && (a == k);
  endfunction

  function automatic logic [EVW-1:0] ev_wrap(input logic [EVW+1:0] v);
    if (v >= (EVW+2)'(EV_DEPTH)) begin
      return EVW'(v - (EVW+2)'(EV_DEPTH));
    end
    return EVW'(v);
  endfunction

  function automatic logic [3:0] rec_wrap(input logic [4:0] v);
    if (v >= 5'(MAX_RECORDS)) begin
      return 4'(v - 5'(MAX_RECORDS));
    end
    return 4'(v);
  endfunction

  function automatic logic ch_ok(input logic [5:0] c, input logic [63:0] av,
                                 input logic [3:0] sr);
    return av[c] && ((c < CH_DERIV_BASE) || (sr >= SR_20MS));
  endfunction

  // ----------------------------------------------------------------
  // event buffer
  // ----------------------------------------------------------------
  logic [7:0] ev_chan_m [EV_DEPTH];
  logic [7:0] ev_code_m [EV_DEPTH];
  logic [15:0] ev_fault_m [EV_DEPTH];
  logic [31:0] ev_time_m [EV_DEPTH];
  logic ev_ovf_m [EV_DEPTH];
  logic ev_sync_m [EV_DEPTH];
  logic [EVW-1:0] ev_head;
  logic [EVW:0] ev_count;
  logic [EVW:0] ev_sel;
  logic [3:0] ev_ctrl;
  logic [15:0] pri_ratio;
  logic ev_full, wipe, ack;
  logic [EVW-1:0] ev_tail, ev_idx;

  assign ev_full = ev_count == (EVW+1)'(EV_DEPTH);
  assign wipe = hit(i_wr, i_addr, A_EV_CMD) && i_wdata[CMD_WIPE];
  assign ack = hit(i_wr, i_addr, A_EV_CMD) && i_wdata[CMD_ACK];
  assign ev_tail = ev_wrap({1'b0, ev_count} + (EVW+2)'(ev_head));

  // when full the tail lands on the oldest entry, so it is overwritten
  always_ff @(posedge i_clk) begin
    if (i_ev_valid) begin
      ev_chan_m[ev_tail] <= i_ev_chan;
      ev_code_m[ev_tail] <= i_ev_code;
      ev_fault_m[ev_tail] <= i_ev_fault;
      ev_time_m[ev_tail] <= i_time;
      ev_ovf_m[ev_tail] <= ev_full && !wipe;
      ev_sync_m[ev_tail] <= i_time_synced;
    end
  end

  // pointers; an event beside a wipe survives as the only entry
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_head <= '0;
      ev_count <= '0;
    end else if (wipe) begin
      ev_head <= i_ev_valid ? ev_tail : '0;
      ev_count <= i_ev_valid ? (EVW+1)'(1) : '0;
    end else if (i_ev_valid) begin
      if (ev_full) begin
        ev_head <= ev_wrap((EVW+2)'(ev_head) + (EVW+2)'(1));
      end else begin
        ev_count <= ev_count + (EVW+1)'(1);
      end
    end
  end

  // popup: new event sets, ack clears, set wins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_popup <= 1'b0;
    end else if (i_ev_valid && ev_ctrl[EC_POPUP]) begin
      o_popup <= 1'b1;
    end else if (ack || !ev_ctrl[EC_POPUP]) begin
      o_popup <= 1'b0;
    end
  end

  // display slot k counts from the oldest or from the newest entry
  always_comb begin
    if (ev_ctrl[EC_ORDER]) begin
      ev_idx = ev_wrap((EVW+2)'(ev_head) +
                       (EVW+2)'(ev_count - 1'b1 - ev_sel));
    end else begin
      ev_idx = ev_wrap((EVW+2)'(ev_head) + (EVW+2)'(ev_sel));
    end
  end

  // ----------------------------------------------------------------
  // recorder settings and sample clock
  // ----------------------------------------------------------------
  logic dr_en, dr_ovw;
  logic [3:0] sr;
  logic [6:0] pct;
  logic [15:0] dr_len;
  logic [TRIG_W-1:0] trig_col, trig_prev;
  logic [31:0] rsel;
  logic [31:0] ms_cnt;
  logic ms_tick, samp_tick;
  logic [15:0] iv_cnt;
  logic [1:0] wdiv, wmask;
  logic [3:0] sr_eff;
  logic [6:0] pct_eff;
  logic [15:0] pre_len;

  assign sr_eff = (sr > SR_LAST) ? SR_LAST : sr;
  assign pct_eff = (pct > 7'(PCT_MAX)) ? 7'(PCT_MAX) : pct;
  assign pre_len = 16'((32'(dr_len) * 32'(pct_eff)) / 32'(PCT_MAX));
  assign wmask = (sr_eff == 4'h0) ? 2'h0 : (sr_eff == 4'h1) ? 2'h1 : 2'h3;

  // millisecond enable, then waveform divide or interval count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_cnt == 32'(MS_CYCLES - 1);
      ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdiv <= '0;
      iv_cnt <= '0;
      samp_tick <= 1'b0;
    end else if (sr_eff <= SR_8C) begin
      iv_cnt <= '0;
      if (i_wave_tick) begin
        wdiv <= wdiv + 2'h1;
      end
      samp_tick <= i_wave_tick && ((wdiv & wmask) == 2'h0);
    end else begin
      wdiv <= '0;
      samp_tick <= ms_tick && (iv_cnt == SR_MS[sr_eff] - 16'h1);
      if (ms_tick) begin
        iv_cnt <= (iv_cnt >= SR_MS[sr_eff] - 16'h1) ? '0 : iv_cnt + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel list
  // ----------------------------------------------------------------
  logic [5:0] ch_code [MAX_CHANNELS];
  logic [MAX_CHANNELS-1:0] ch_valid, ch_bad;
  logic [5:0] add_raw, add_code;
  logic add_cmd, clr_cmd, add_ok, dup, have_free;
  logic [3:0] free_idx, nch, nderiv;

  assign add_cmd = hit(i_wr, i_addr, A_DR_CMD) && i_wdata[RC_ADD];
  assign clr_cmd = hit(i_wr, i_addr, A_DR_CMD) && i_wdata[RC_CLR];
  assign add_raw = i_wdata[RC_CODE_LSB +: 6];
  assign add_code = (add_raw == CH_ARC) ? CH_DI : add_raw;

  always_comb begin
    dup = 1'b0;
    have_free = 1'b0;
    free_idx = '0;
    nch = '0;
    nderiv = '0;
    for (int i = MAX_CHANNELS - 1; i >= 0; i--) begin
      ch_bad[i] = ch_valid[i] && !ch_ok(ch_code[i], i_chan_avail, sr_eff);
      if (ch_valid[i]) begin
        nch = nch + 4'h1;
        nderiv = nderiv + 4'(ch_code[i] >= CH_DERIV_BASE);
        dup = dup || (ch_code[i] == add_code);
      end else begin
        have_free = 1'b1;
        free_idx = 4'(i);
      end
    end
  end

  assign add_ok = add_cmd && !clr_cmd && have_free && !dup &&
                  ch_ok(add_code, i_chan_avail, sr_eff);

  // slots: clear wins, then automatic drop, then add into first free
  for (genvar g = 0; g < MAX_CHANNELS; g++) begin : g_slot
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ch_valid[g] <= 1'b0;
        ch_code[g] <= '0;
      end else if (clr_cmd) begin
        ch_valid[g] <= 1'b0;
      end else if (ch_bad[g]) begin
        ch_valid[g] <= 1'b0;
      end else if (add_ok && free_idx == 4'(g)) begin
        ch_valid[g] <= 1'b1;
        ch_code[g] <= add_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // capture control and record table
  // ----------------------------------------------------------------
  elr_state_t st;
  logic [15:0] smem [SAMP_DEPTH];
  logic [SW-1:0] wptr, cap_start;
  logic [31:0] cap_time;
  logic [15:0] pre_fill, post_left, max_capture_length;
  logic [31:0] rec_time [MAX_RECORDS];
  logic [SW-1:0] rec_start [MAX_RECORDS];
  logic [3:0] rhead, rcount, next_rhead, next_rcount, mrec, slot, rslot;
  logic trig_take, commit, free, samp_wr, man_cmd;
  logic [31:0] q, units;

  assign man_cmd = hit(i_wr, i_addr, A_DR_CMD) && i_wdata[RC_MAN];
  assign free = hit(i_wr, i_addr, A_DR_CMD) && i_wdata[RC_FREE] &&
                (rcount != 4'h0);
  // edge on any source picked in the trigger column, or operator request
  assign trig_take = (st == ST_ARMED) && (dr_ovw || rcount < mrec) &&
                     ((|(i_trig & ~trig_prev & trig_col)) || man_cmd);
  assign commit = (st == ST_CAPT) &&
                  (post_left == 16'h0 || (samp_tick && post_left == 16'h1));
  assign samp_wr = samp_tick && ((st == ST_ARMED) ||
                   (st == ST_CAPT && post_left != 16'h0));

  // allowed record count: memory holds whole records only, max twelve
  always_comb begin
    q = (dr_len == 16'h0) ? 32'(MAX_RECORDS) : 32'(SAMP_DEPTH) / 32'(dr_len);
    mrec = (q > 32'(MAX_RECORDS)) ? 4'(MAX_RECORDS) : 4'(q);
    units = 32'(nch) + 32'(nderiv);
    q = (units == 32'h0) ? 32'(SAMP_DEPTH) : 32'(SAMP_DEPTH) / units;
    max_capture_length = (q < 32'(dr_len)) ? 16'(q) : dr_len;
  end

  // bookkeeping; a commit beyond the limit drops the oldest record
  always_comb begin
    next_rhead = rhead;
    next_rcount = rcount;
    if (free) begin
      next_rhead = rec_wrap({1'b0, rhead} + 5'h1);
      next_rcount = rcount - 4'h1;
    end
    slot = rec_wrap({1'b0, next_rhead} + {1'b0, next_rcount});
    if (commit) begin
      if (next_rcount < mrec) begin
        next_rcount = next_rcount + 4'h1;
      end else begin
        // new record still lands on the tail; dropping the head keeps order
        next_rhead = rec_wrap({1'b0, next_rhead} + 5'h1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (samp_wr) begin
      smem[wptr] <= i_sample;
    end
    if (commit) begin
      rec_time[slot] <= cap_time;
      rec_start[slot] <= cap_start;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_prev <= '0;
      rhead <= '0;
      rcount <= '0;
    end else begin
      trig_prev <= i_trig;
      rhead <= next_rhead;
      rcount <= next_rcount;
    end
  end

  // recorder state machine; the full test comes before any trigger
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= ST_IDLE;
      wptr <= '0;
      pre_fill <= '0;
      post_left <= '0;
      cap_time <= '0;
      cap_start <= '0;
    end else begin
      if (samp_wr) begin
        wptr <= wptr + SW'(1);
      end
      case (st)
        ST_IDLE: begin
          pre_fill <= '0;
          if (dr_en) begin
            st <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (samp_wr && pre_fill < pre_len) begin
            pre_fill <= pre_fill + 16'h1;
          end
          if (!dr_en) begin
            st <= ST_IDLE;
          end else if (!dr_ovw && rcount >= mrec) begin
            st <= ST_FULL;
          end else if (trig_take) begin
            st <= ST_CAPT;
            post_left <= dr_len - pre_len;
            cap_time <= i_time;
            cap_start <= wptr - SW'(pre_fill);
          end
        end
        ST_CAPT: begin
          if (samp_wr) begin
            post_left <= post_left - 16'h1;
          end
          if (commit) begin
            st <= ST_ARMED;
            pre_fill <= '0;
          end
        end
        ST_FULL: begin
          pre_fill <= '0;
          if (!dr_en) begin
            st <= ST_IDLE;
          end else if (dr_ovw || rcount < mrec) begin
            st <= ST_ARMED;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rec_status <= 2'h0;
    end else begin
      o_rec_status <= st;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_ctrl <= EV_CTRL_RST;
      pri_ratio <= PRI_RATIO_RST;
      ev_sel <= '0;
      dr_en <= 1'b0;
      dr_ovw <= 1'b0;
      sr <= SR_RST;
      pct <= PCT_RST;
      dr_len <= DR_LEN_RST;
      trig_col <= '0;
      rsel <= '0;
    end else if (i_wr) begin
      case (i_addr)
        A_EV_CTRL: ev_ctrl <= i_wdata[3:0];
        A_EV_SEL: ev_sel <= i_wdata[EVW:0];
        A_PRI_RATIO: pri_ratio <= i_wdata[15:0];
        A_DR_CTRL: begin
          dr_en <= i_wdata[DC_EN];
          dr_ovw <= i_wdata[DC_OVW];
          sr <= i_wdata[DC_SR_LSB +: 4];
          pct <= i_wdata[DC_PCT_LSB +: 7];
        end
        A_DR_LEN: dr_len <= i_wdata[15:0];
        A_DR_TRIG_COL: trig_col <= i_wdata[TRIG_W-1:0];
        A_DR_RSEL: rsel <= i_wdata;
        default: ;
      endcase
    end
  end

  assign rslot = rec_wrap({1'b0, rhead} + {1'b0, rsel[3:0]});

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else begin
      case (i_addr)
        A_EV_CTRL: o_rdata <= {28'h0, ev_ctrl};
        A_EV_COUNT: o_rdata <= 32'(ev_count);
        A_EV_SEL: o_rdata <= 32'(ev_sel);
        A_EV_CODE: o_rdata <= {13'h0, ev_ovf_m[ev_idx],
          ev_ctrl[EC_SYNCFMT] && !ev_sync_m[ev_idx],
          ev_chan_m[ev_idx] != 8'h0,
          ev_chan_m[ev_idx], ev_code_m[ev_idx]};
        A_EV_TIME: o_rdata <= ev_time_m[ev_idx];
        A_EV_FAULT: o_rdata <= ev_ctrl[EC_SCALE] ?
          32'(ev_fault_m[ev_idx]) * 32'(pri_ratio) :
          32'(ev_fault_m[ev_idx]);
        A_PRI_RATIO: o_rdata <= 32'(pri_ratio);
        A_DR_CTRL: o_rdata <= {17'h0, pct, sr, 2'h0, dr_ovw, dr_en};
        A_DR_LEN: o_rdata <= 32'(dr_len);
        A_DR_TRIG_COL: o_rdata <= 32'(trig_col);
        A_DR_STATUS: o_rdata <= {12'h0, mrec, 4'h0, rcount, 6'h0,
                                 st};
        A_DR_CHCNT: o_rdata <= {24'h0, nderiv, nch};
        A_DR_MAX_CAPTURE_LENGTH: o_rdata <= 32'(max_capture_length);
        A_DR_RSEL: o_rdata <= rsel;
        A_DR_RTIME: o_rdata <= rec_time[rslot];
        A_DR_RDATA: o_rdata <= 32'(smem[SW'(rec_start[rslot] +
                                        SW'(rsel[31:16]))]);
        default: o_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_armed_trig;
    (st == ST_ARMED) && dr_en && trig_take;
  endsequence

  property p_ovf;
    i_ev_valid && ev_full && !wipe |=> ev_full && ev_ovf_m[$past(ev_tail)];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not marked");

  property p_popup;
    i_ev_valid && ev_ctrl[EC_POPUP] |=> o_popup;
  endproperty
  a_popup: assert property (p_popup) else $error("popup missed");

  property p_rec_max;
    rcount <= 4'(MAX_RECORDS) && rcount <= mrec + 4'h1;
  endproperty
  a_rec_max: assert property (p_rec_max) else $error("too many records");

  property p_clear;
    clr_cmd |=> ch_valid == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_drop;
    ch_bad != '0 && !add_ok |=> (ch_valid & $past(ch_bad)) == '0;
  endproperty
  a_drop: assert property (p_drop) else $error("bad channel kept");

  property p_sat;
    (st == ST_FULL) && dr_en && rcount >= mrec |=> st != ST_CAPT;
  endproperty
  a_sat: assert property (p_sat) else $error("capture while full");

  property p_manual;
    (st == ST_ARMED) && dr_en && man_cmd && (dr_ovw || rcount < mrec)
      |=> st == ST_CAPT;
  endproperty
  a_manual: assert property (p_manual) else $error("manual ignored");

  property p_post;
    s_armed_trig |=> post_left == $past(dr_len - pre_len) &&
                     cap_time == $past(i_time);
  endproperty
  a_post: assert property (p_post) else $error("bad post count");

  property p_status;
    ##1 o_rec_status == $past(st);
  endproperty
  a_status: assert property (p_status) else $error("status lag");
endmodule // elr_top

/* File: verification/elr_host.sv */
// host tool model: plain register port master
// assumes the slave never stalls, read data the cycle after
`timescale 1ns/1ps
module elr_host (
  input wire logic i_clk, // system clock
  output logic [7:0] o_addr, // byte address
  output logic [31:0] o_wdata, // write data
  output logic o_wr, // write strobe
  output logic o_rd // read strobe
);
  // idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle strobe; the trailing edge keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
  endtask
endmodule // elr_host

/* File: verification/test_elr_top.sv */
// self-checking bench for the event log and recorder
// assumes elr_host drives the register port
`timescale 1ns/1ps
module test_elr_top;
  import elr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, tm;
  logic wr, rd, popup;
  logic evv = 1'b0;
  logic pend = 1'b0;
  logic wtick = 1'b0;
  logic [7:0] ech = 8'h0;
  logic [7:0] ecode = 8'h0;
  logic [15:0] samp = 16'h0;
  logic sync = 1'b0;
  logic [15:0] trg = 16'h0;
  logic [63:0] avail = '1;
  logic [1:0] st;
  logic [31:0] exp_q[$];
  logic [7:0] chs[5], cds[5];
  int err_count = 0;
  int n_compared = 0;

  elr_top #(.EV_DEPTH(4), .MS_CYCLES(10)) i_elr_top (.i_clk(clk),
    .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_ev_valid(evv), .i_ev_chan(ech),
    .i_ev_code(ecode), .i_ev_fault(16'h0100), .i_time(tm),
    .i_time_synced(sync), .i_wave_tick(wtick), .i_sample(samp),
    .i_trig(trg), .i_chan_avail(avail), .o_popup(popup),
    .o_rec_status(st));
  elr_host i_elr_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  initial forever #5 clk = ~clk;

  // sample pulse every fourth cycle, random words
  initial forever begin
    repeat (3) @(posedge clk);
    wtick <= 1'b1;
    samp <= 16'($urandom);
    @(posedge clk);
    wtick <= 1'b0;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (pend) begin
      cmp(rdata, exp_q.pop_front());
    end
    pend <= rd;
  end

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_elr_host.rd(a);
  endtask
  task automatic ev(input logic [7:0] c, input logic [7:0] k);
    @(posedge clk);
    ech <= c;
    ecode <= k;
    evv <= 1'b1;
    @(posedge clk);
    evv <= 1'b0;
  endtask
  task automatic results();
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h0e514140));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tm <= $urandom;
    rd_chk(A_EV_CTRL, 32'h0);
    rd_chk(A_PRI_RATIO, 32'h1);
    rd_chk(A_DR_LEN, 32'h64);
    rd_chk(8'hfc, 32'h0);
    // five events into four slots; last one on channel zero
    i_elr_host.wr(A_EV_CTRL, 32'hd);
    i_elr_host.wr(A_EV_SEL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      chs[i] = (i == 4) ? 8'h0 : 8'($urandom_range(255, 1));
      cds[i] = 8'($urandom);
      ev(chs[i], cds[i]);
    end
    rd_chk(A_EV_COUNT, 32'h4);
    rd_chk(A_EV_CODE, {13'h0, 3'b110, chs[4], cds[4]});
    cmp(32'(popup), 32'h1);
    i_elr_host.wr(A_EV_CTRL, 32'h8);
    rd_chk(A_EV_CODE, {13'h0, 3'b011, chs[1], cds[1]});
    cmp(32'(popup), 32'h0);
    i_elr_host.wr(A_PRI_RATIO, 32'h3);
    i_elr_host.wr(A_EV_CTRL, 32'h2);
    rd_chk(A_EV_FAULT, 32'h300);
    // a synchronised stamp is shown plainly
    sync <= 1'b1;
    ev(chs[0], cds[0]);
    i_elr_host.wr(A_EV_CTRL, 32'h9);
    rd_chk(A_EV_CODE, {13'h0, 3'b101, chs[0], cds[0]});
    // recorder: arm, channel list, manual capture
    i_elr_host.wr(A_DR_CTRL, 32'h3201);
    rd_chk(A_DR_STATUS, 32'h000a0001);
    i_elr_host.wr(A_DR_CMD, 32'h2002);
    rd_chk(A_DR_CHCNT, 32'h0);
    i_elr_host.wr(A_DR_CMD, 32'h1102);
    i_elr_host.wr(A_DR_CMD, 32'h1002);
    rd_chk(A_DR_CHCNT, 32'h1);
    i_elr_host.wr(A_DR_CMD, 32'h4);
    rd_chk(A_DR_CHCNT, 32'h0);
    i_elr_host.wr(A_DR_CMD, 32'h0102);
    rd_chk(A_DR_MAX_CAPTURE_LENGTH, 32'h64);
    // derived code accepted at a slow rate, dropped once unavailable
    i_elr_host.wr(A_DR_CTRL, 32'h3241);
    i_elr_host.wr(A_DR_CMD, 32'h2002);
    rd_chk(A_DR_CHCNT, 32'h12);
    avail <= 64'hfffffffe_ffffffff;
    rd_chk(A_DR_CHCNT, 32'h1);
    avail <= '1;
    i_elr_host.wr(A_DR_CTRL, 32'h3201);
    repeat (300) @(posedge clk);
    i_elr_host.wr(A_DR_CMD, 32'h1);
    rd_chk(A_DR_STATUS, 32'h000a0002);
    cmp(32'(st), 32'h2);
    repeat (400) @(posedge clk);
    rd_chk(A_DR_STATUS, 32'h000a0101);
    rd_chk(A_DR_RTIME, tm);
    // column trigger: a masked-out edge is ignored, a selected one fires
    tm <= $urandom;
    i_elr_host.wr(A_DR_TRIG_COL, 32'h4);
    trg <= 16'h2;
    rd_chk(A_DR_STATUS, 32'h000a0101);
    trg <= 16'h6;
    rd_chk(A_DR_STATUS, 32'h000a0102);
    repeat (250) @(posedge clk);
    i_elr_host.wr(A_DR_RSEL, 32'h1);
    rd_chk(A_DR_RTIME, tm);
    cmp(32'(st), 32'h1);
    // longer records: two fill memory, saturating mode refuses a third
    i_elr_host.wr(A_DR_LEN, 32'h200);
    rd_chk(A_DR_STATUS, 32'h00020203);
    i_elr_host.wr(A_DR_CMD, 32'h1);
    cmp(32'(st), 32'h3);
    rd_chk(A_DR_STATUS, 32'h00020203);
    // overwrite mode re-arms and replaces the oldest record
    tm <= $urandom;
    i_elr_host.wr(A_DR_CTRL, 32'h3203);
    i_elr_host.wr(A_DR_CMD, 32'h1);
    rd_chk(A_DR_STATUS, 32'h00020202);
    repeat (1100) @(posedge clk);
    rd_chk(A_DR_STATUS, 32'h00020201);
    rd_chk(A_DR_RTIME, tm);
    i_elr_host.wr(A_DR_CMD, 32'h8);
    i_elr_host.wr(A_DR_RSEL, 32'h0);
    rd_chk(A_DR_STATUS, 32'h00020101);
    rd_chk(A_DR_RTIME, tm);
    repeat (2) @(posedge clk);
    results();
  end

  // hang guard, well past the expected run
  initial begin
    #200us;
    err_count++;
    results();
  end
endmodule // test_elr_top
